/* tb/pctu_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: encoder, capture source and emergency stop
module pctu_far_side (
  input  wire logic                 ref_clk,
  output var  pctu_pkg::pctu_pins_s pins
);
  logic [1:0] phase; // Quadrature position 0..3

  // All pins idle low at start
  initial begin
    pins  = '0;
    phase = 2'h0;
  end

  // Hold a new level well past the input filter
  task automatic settle();
    repeat (10) @(negedge ref_clk);
  endtask : settle

  // One quadrature edge, A leads B when going forward
  task automatic enc_step(input logic fwd);
    @(negedge ref_clk);
    phase     = fwd ? phase + 2'h1 : phase - 2'h1;
    pins.encA = phase[1] ^ phase[0];
    pins.encB = phase[1];
    settle();
  endtask : enc_step

  // Rising then falling edge on one capture input
  task automatic cap_pulse(input int ch);
    pins.capIn[ch] = 1'b1;
    settle();
    pins.capIn[ch] = 1'b0;
    settle();
  endtask : cap_pulse

  // Hall sensor levels, held past the input filter
  task automatic set_hall(input logic [2:0] v);
    pins.hall = v;
    settle();
  endtask : set_hall

  // Emergency stop level, applied at once
  task automatic set_estop(input logic v);
    pins.estop = v;
  endtask : set_estop
endmodule : pctu_far_side
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
// ==========================================================
// Bench top
module tb_top;
  logic                          ref_clk = 1'b0;
  logic                          rst     = 1'b1;
  pctu_pkg::pctu_cfg_s           cfg;
  pctu_pkg::pctu_ch_cfg_s  [3:0] chCfg;
  pctu_pkg::pctu_pins_s          pins;
  logic                          linkTrigIn;
  logic                          debugHalt;
  logic                   [15:0] count;
  logic              [3:0][15:0] capture;
  logic                          countDown;
  logic                    [3:0] chOut;
  logic                    [2:0] compOut;
  logic                          linkTrigOut;
  logic                          dmaUpdate;
  logic                    [3:0] dmaChannel;
  int                            fail_count  = 0;
  int                            comparisons = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  pctu_far_side FAR (.ref_clk(ref_clk), .pins(pins));

  pctu_timer DUT (
    .ref_clk(ref_clk), .rst(rst), .cfg(cfg), .chCfg(chCfg), .pins(pins), .linkTrigIn(linkTrigIn),
    .debugHalt(debugHalt), .count(count), .capture(capture), .countDown(countDown), .chOut(chOut),
    .compOut(compOut), .linkTrigOut(linkTrigOut), .dmaUpdate(dmaUpdate), .dmaChannel(dmaChannel));

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Short reset with all configuration cleared
  task automatic restart();
    rst        = 1'b1;
    cfg        = '0;
    chCfg      = '0;
    linkTrigIn = 1'b0;
    debugHalt  = 1'b0;
    cyc(2);
    rst = 1'b0;
  endtask : restart

  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Scenarios
  // Up count walk, wrap and update pulse
  task automatic t_up();
    restart();
    cfg.prescale   = 16'h0001;
    cfg.autoReload = 16'h0002;
    cfg.enable     = 1'b1;
    cyc(2); `CHK(count, 16'h0001, "first step")
    cyc(2); `CHK(count, 16'h0002, "second step")
    cyc(2); `CHK(count, 16'h0000, "wrap")
    `CHK(dmaUpdate, 1'b1, "update request")
    `CHK(linkTrigOut, 1'b1, "link trigger")
    cyc(1); `CHK(dmaUpdate, 1'b0, "request one cycle")
  endtask : t_up

  // Largest division factor
  task automatic t_prescale_max();
    restart();
    cfg.prescale   = 16'hFFFF;
    cfg.autoReload = 16'hFFFF;
    cfg.enable     = 1'b1;
    cyc(65535); `CHK(count, 16'h0000, "no step before 65536")
    cyc(1); `CHK(count, 16'h0001, "step at 65536")
  endtask : t_prescale_max

  // Down count wraps from zero to the top
  task automatic t_down();
    logic [15:0] exp[5];
    exp = '{16'h0003, 16'h0002, 16'h0001, 16'h0000, 16'h0003};
    restart();
    cfg.cntMode    = pctu_pkg::CNT_DOWN;
    cfg.autoReload = 16'h0003;
    cfg.enable     = 1'b1;
    foreach (exp[i]) begin
      cyc(1); `CHK(count, exp[i], "down sequence")
    end
    `CHK(countDown, 1'b1, "direction down")
  endtask : t_down

  // High cycles of channel 3 over one period
  task automatic pwm_case(input pctu_pkg::pctu_cnt_mode_e m, input logic [15:0] cmp, input int per, input int hi);
    int n;
    restart();
    n                = 0;
    cfg.cntMode      = m;
    cfg.autoReload   = 16'h0004;
    cfg.enable       = 1'b1;
    chCfg[3].mode    = pctu_pkg::CH_PWM;
    chCfg[3].compare = cmp;
    cyc(20);
    repeat (per) begin
      cyc(1);
      n += (chOut[3] === 1'b1) ? 1 : (chOut[3] === 1'b0) ? 0 : per + 1;
    end
    `CHK(n, hi, "pwm high count")
  endtask : pwm_case

  // Complementary pairs with dead-time gap
  task automatic t_deadtime();
    int gap[3];
    logic bothHigh;
    restart();
    gap            = '{0, 0, 0};
    bothHigh       = 1'b0;
    cfg.deadTime   = 8'h03;
    cfg.autoReload = 16'h0004;
    cfg.enable     = 1'b1;
    for (int i = 0; i < 3; i++) chCfg[i].mode = pctu_pkg::CH_PWM;
    cyc(10); `CHK({chOut[2:0], compOut}, 6'h07, "full off pairs")
    for (int i = 0; i < 3; i++) chCfg[i].compare = 16'h0005;
    repeat (20) begin
      cyc(1);
      for (int i = 0; i < 3; i++) begin
        gap[i] += int'(chOut[i] === 1'b0 && compOut[i] === 1'b0);
        bothHigh |= chOut[i] & compOut[i];
      end
    end
    for (int i = 0; i < 3; i++) `CHK(gap[i], 4, "dead-time gap")
    `CHK(bothHigh, 1'b0, "pair overlap")
    `CHK({chOut[2:0], compOut}, 6'h38, "full on three phases")
  endtask : t_deadtime

  // Debug halt freezes counter and makes outputs safe
  task automatic t_debug();
    logic [15:0] hold;
    restart();
    cfg.autoReload         = 16'h0004;
    cfg.freezeInDebug      = 1'b1;
    cfg.stopOutputsInDebug = 1'b1;
    cfg.enable             = 1'b1;
    chCfg[3].mode          = pctu_pkg::CH_PWM;
    chCfg[3].compare       = 16'h0005;
    cyc(10); `CHK(chOut[3], 1'b1, "full on")
    debugHalt = 1'b1;
    cyc(2);
    hold = count;
    cyc(5); `CHK(count, hold, "frozen")
    `CHK(chOut, 4'h0, "safe in debug")
    debugHalt = 1'b0;
    cyc(3); `CHK(count !== hold, 1'b1, "runs again")
  endtask : t_debug

  // Emergency stop forces safe levels without a clock edge
  task automatic t_estop();
    restart();
    cfg.autoReload   = 16'h0004;
    cfg.enable       = 1'b1;
    chCfg[0].mode    = pctu_pkg::CH_PWM;
    chCfg[0].compare = 16'h0005;
    cyc(20); `CHK(chOut[0], 1'b1, "on before stop")
    FAR.set_estop(1'b1);
    #1; `CHK({chOut, compOut}, 7'h00, "async safe")
    cyc(3); `CHK({chOut, compOut}, 7'h00, "stays safe")
    FAR.set_estop(1'b0);
  endtask : t_estop

  // Quadrature steps forward then back
  task automatic t_encoder();
    restart();
    cfg.src        = pctu_pkg::SRC_ENCODER;
    cfg.autoReload = 16'h0064;
    cfg.enable     = 1'b1;
    repeat (4) FAR.enc_step(1'b1);
    `CHK(count, 16'h0004, "encoder forward")
    repeat (2) FAR.enc_step(1'b0);
    `CHK(count, 16'h0002, "encoder back")
    `CHK(countDown, 1'b1, "encoder direction")
  endtask : t_encoder

  // Capture on channel 1, compare match on channel 2
  task automatic t_capture();
    logic [15:0] lo;
    logic seen1;
    logic seen2;
    restart();
    seen1            = 1'b0;
    seen2            = 1'b0;
    cfg.autoReload   = 16'hFFFF;
    cfg.enable       = 1'b1;
    chCfg[0].mode    = pctu_pkg::CH_ONEPULSE;
    chCfg[1].mode    = pctu_pkg::CH_CAPTURE;
    chCfg[2].mode    = pctu_pkg::CH_COMPARE;
    chCfg[2].compare = 16'h0020;
    cyc(20);
    lo = count;
    fork
      FAR.cap_pulse(1);
      repeat (22) begin
        cyc(1);
        seen1 |= dmaChannel[1];
        seen2 |= dmaChannel[2];
      end
    join
    `CHK(capture[1] > lo && capture[1] < count, 1'b1, "captured value")
    `CHK({seen1, seen2}, 2'b11, "channel requests")
  endtask : t_capture

  // Link trigger restarts a reset-mode slave
  task automatic t_link();
    logic zero;
    logic upd;
    restart();
    zero           = 1'b0;
    upd            = 1'b0;
    cfg.slave      = pctu_pkg::SLV_RESET;
    cfg.prescale   = 16'h0009;
    cfg.autoReload = 16'hFFFF;
    cfg.enable     = 1'b1;
    cyc(35);
    linkTrigIn = 1'b1;
    cyc(1);
    linkTrigIn = 1'b0;
    repeat (3) begin
      zero |= (count === 16'h0000);
      upd  |= dmaUpdate;
      cyc(1);
    end
    `CHK({zero, upd}, 2'b11, "slave reset")
    // Clock slave: each trigger pulse is one step
    cfg.slave = pctu_pkg::SLV_CLOCK;
    repeat (2) begin
      linkTrigIn = 1'b1;
      cyc(1);
      linkTrigIn = 1'b0;
      cyc(1);
    end
    `CHK(count, 16'h0002, "clock slave")
    // Start slave: frozen until a trigger arrives
    cfg.slave = pctu_pkg::SLV_START;
    cyc(3); `CHK(count, 16'h0002, "start slave waits")
    linkTrigIn = 1'b1;
    cyc(1);
    linkTrigIn = 1'b0;
    cyc(10); `CHK(count, 16'h0003, "start slave runs")
  endtask : t_link

  // Hall change captures the interval and restarts the count
  task automatic t_hall();
    restart();
    cfg.src        = pctu_pkg::SRC_HALL;
    cfg.autoReload = 16'hFFFF;
    cfg.enable     = 1'b1;
    cyc(10);
    FAR.set_hall(3'h1);
    `CHK(capture[0] > 16'h0009 && count < 16'h000A, 1'b1, "hall capture")
  endtask : t_hall

  // ==========================================================
  // Main sequence
  initial begin
    cfg        = '0;
    chCfg      = '0;
    linkTrigIn = 1'b0;
    debugHalt  = 1'b0;
    cyc(6);
    t_up();
    t_down();
    pwm_case(pctu_pkg::CNT_UP, 16'h0002, 5, 2);
    pwm_case(pctu_pkg::CNT_CENTER, 16'h0002, 8, 3);
    pwm_case(pctu_pkg::CNT_UP, 16'h0000, 5, 0);
    pwm_case(pctu_pkg::CNT_UP, 16'h0005, 5, 5);
    t_deadtime();
    t_debug();
    t_estop();
    t_encoder();
    t_capture();
    t_link();
    t_hall();
    t_prescale_max();
    tally_and_finish();
  end

  // Watchdog well beyond the expected run
  initial begin
    #1800000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire

/* verilog/pctu_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module pctu_channel (
  input  wire logic                   [1:0] mode,
  input  wire logic                  [15:0] compare,
  input  wire logic                  [15:0] count,
  input  wire logic                         toggle,
  output logic                              refLevel,
  output logic                              match
);

  // ==========================================================
  // Reference level of one channel
  always_comb begin
    match = (count == compare);
    unique case (pctu_pkg::pctu_ch_mode_e'(mode))
      // Compare above top gives full on, zero gives full off
      pctu_pkg::CH_PWM, pctu_pkg::CH_ONEPULSE: refLevel = (count < compare);
      pctu_pkg::CH_COMPARE:                    refLevel = toggle;
      pctu_pkg::CH_CAPTURE:                    refLevel = 1'b0;
    endcase
  end

endmodule : pctu_channel
`default_nettype wire

/* verilog/pctu_deadtime.sv */
`timescale 1ns/1ps
`default_nettype none
module pctu_deadtime #(
  parameter int DT_W = pctu_pkg::DT_W
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            refLevel,
  input  wire logic [DT_W-1:0] deadTime,
  output logic                 mainOut,
  output logic                 compOut
);

  typedef struct packed {
    logic            prevRef; // Reference seen last cycle
    logic [DT_W-1:0] wait_;   // Remaining dead-time
  } pctu_dt_s;

  pctu_dt_s st;      // Registered state
  pctu_dt_s next_st; // Next state

  // ==========================================================
  // Dead-time counter reloads on each reference edge
  always_comb begin
    next_st = st;
    next_st.prevRef = refLevel;
    if (refLevel != st.prevRef) begin
      next_st.wait_ = deadTime;
    end else if (st.wait_ != '0) begin
      next_st.wait_ = st.wait_ - 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Neither side turns on before the gap expires
  always_comb begin
    mainOut = refLevel && (refLevel == st.prevRef) && (st.wait_ == '0);
    compOut = !refLevel && (refLevel == st.prevRef) && (st.wait_ == '0);
  end

  AST_DT_GAP: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(refLevel) && deadTime != '0) |-> !mainOut ##1 (!mainOut || !refLevel))
    else $error("Main output turned on inside dead-time");

endmodule : pctu_deadtime
`default_nettype wire

/* verilog/pctu_pkg.sv */
`default_nettype none
package pctu_pkg;

  // ==========================================================
  // Widths, counts and reset values
  localparam int          CNT_W     = 16;    // Counter and prescaler width
  localparam int          NUM_CH    = 4;     // Channels per timer
  localparam int          NUM_PAIRS = 3;     // Complementary pairs (advanced)
  localparam int          DT_W      = 8;     // Dead-time count width
  localparam int          PIN_W     = 10;    // Synchronised pin inputs
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_CENTER} pctu_cnt_mode_e;
  typedef enum logic [1:0] {CH_CAPTURE, CH_COMPARE, CH_PWM, CH_ONEPULSE} pctu_ch_mode_e;
  typedef enum logic [1:0] {SRC_INTERNAL, SRC_ENCODER, SRC_HALL} pctu_src_e;
  typedef enum logic [1:0] {SLV_OFF, SLV_RESET, SLV_START, SLV_CLOCK} pctu_slave_e;

  // ==========================================================
  // Configuration and pin groups
  typedef struct packed {
    logic           enable;             // Counter enable
    pctu_cnt_mode_e cntMode;            // Counting direction mode
    pctu_src_e      src;                // Count source
    pctu_slave_e    slave;              // Reaction to link trigger
    logic [15:0]    prescale;           // Division factor minus one
    logic [15:0]    autoReload;         // Top of count
    logic           freezeInDebug;      // Hold prescaler and counter steps on debug halt
    logic           stopOutputsInDebug; // Safe outputs on debug halt, advanced timer only
    logic [7:0]     deadTime;           // Dead-time gap minus one, in clock cycles
  } pctu_cfg_s;

  typedef struct packed {
    pctu_ch_mode_e mode;          // Channel function
    logic [15:0]   compare;       // Compare or duty value
    logic          captureFalling; // Capture on falling edge
  } pctu_ch_cfg_s;

  typedef struct packed {
    logic       estop;  // Emergency stop, active high
    logic [3:0] capIn;  // Capture inputs
    logic [2:0] hall;   // Hall sensor inputs
    logic       encB;   // Encoder phase B
    logic       encA;   // Encoder phase A
  } pctu_pins_s;

endpackage : pctu_pkg
`default_nettype wire

/* verilog/pctu_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module pctu_timer #(
  parameter bit         ADVANCED  = 1'b1,  // Advanced timer with complementary pairs
  parameter logic [3:0] SAFE_MAIN = 4'h0,  // Safe level of channel outputs
  parameter logic [2:0] SAFE_COMP = 3'h0   // Safe level of complementary outputs
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  input  wire pctu_pkg::pctu_cfg_s             cfg,
  input  wire pctu_pkg::pctu_ch_cfg_s    [3:0] chCfg,
  input  wire pctu_pkg::pctu_pins_s            pins,
  input  wire logic                            linkTrigIn,
  input  wire logic                            debugHalt,
  output logic                          [15:0] count,
  output logic                          [3:0][15:0] capture,
  output logic                                 countDown,
  output logic                           [3:0] chOut,
  output logic                           [2:0] compOut,
  output logic                                 linkTrigOut,
  output logic                                 dmaUpdate,
  output logic                           [3:0] dmaChannel
);

  // ==========================================================
  // Elaboration checks
  if (pctu_pkg::NUM_CH != 4 || pctu_pkg::CNT_W != 16) begin : gBadCfg
    $error("Timer supports four 16-bit channels only");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [9:0]       s1;        // Pin synchroniser stage one
    logic [9:0]       s2;        // Stage two
    logic [9:0]       s3;        // Stage three
    logic [9:0]       filt;      // Agreed pin levels
    logic [9:0]       filtPrev;  // Agreed levels last cycle
    logic [15:0]      psc;       // Prescaler count
    logic [15:0]      cnt;       // Main counter
    logic             down;      // Counting downward
    logic             started;   // Link start received
    logic             stopped;   // One-pulse period done
    logic             stepped;   // Counter moved last cycle
    logic [3:0]       toggle;    // Compare toggle levels
    logic [3:0][15:0] cap;       // Captured values
    logic             upd;       // Update event pulse
    logic [3:0]       dmaCh;     // Channel request pulses
  } pctu_state_s;

  pctu_state_s st;       // Registered state
  pctu_state_s next_st;  // Next state
  logic        active;   // Counter allowed to run
  logic        hold;     // Debug freeze
  logic        center;   // Center-aligned counting
  logic [3:0]  refLevel; // Channel reference levels
  logic [3:0]  match;    // Channel compare matches
  logic [3:0]  rawMain;  // Main outputs before forcing
  logic [2:0]  rawComp;  // Complementary outputs before forcing
  logic        estopAsync; // Raw emergency stop, advanced only
  logic        forceSafe;  // Synchronous safe forcing

  pctu_pkg::pctu_pins_s filt;     // Agreed pins
  pctu_pkg::pctu_pins_s filtPrev; // Agreed pins last cycle

  assign filt     = st.filt;
  assign filtPrev = st.filtPrev;

  // Run conditions
  always_comb begin
    hold   = debugHalt && cfg.freezeInDebug;
    active = cfg.enable && !st.stopped && (cfg.slave != pctu_pkg::SLV_START || st.started);
    center = (cfg.cntMode == pctu_pkg::CNT_CENTER) && (cfg.src != pctu_pkg::SRC_ENCODER);
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic step;
    logic upd;
    logic pscTick;
    logic dirUp;
    step    = 1'b0;
    upd     = 1'b0;
    pscTick = 1'b0;
    dirUp   = !st.down;
    next_st = st;
    // Three-stage pin synchroniser, level taken once stages agree
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < pctu_pkg::PIN_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
    next_st.filtPrev = st.filt;
    next_st.dmaCh    = 4'h0;
    // Start and one-pulse flags clear while disabled
    if (!cfg.enable) begin
      next_st.started = 1'b0;
      next_st.stopped = 1'b0;
    end else if (cfg.slave == pctu_pkg::SLV_START && linkTrigIn) begin
      next_st.started = 1'b1;
    end
    // Prescaler divides by prescale plus one
    if (active && !hold) begin
      if (st.psc >= cfg.prescale) begin
        next_st.psc = pctu_pkg::CNT_RESET;
        pscTick     = 1'b1;
      end else begin
        next_st.psc = st.psc + pctu_pkg::CNT_ONE;
      end
    end
    // Count source
    if (cfg.src == pctu_pkg::SRC_ENCODER) begin
      // Every phase edge counts, direction from phase order
      if (filt.encA != filtPrev.encA || filt.encB != filtPrev.encB) begin
        step  = active && !hold;
        dirUp = filt.encA ^ filtPrev.encB;
      end
    end else if (cfg.slave == pctu_pkg::SLV_CLOCK) begin
      step = linkTrigIn && active && !hold;
    end else begin
      step = pscTick;
    end
    // Direction for plain up or down counting
    if (cfg.src == pctu_pkg::SRC_ENCODER) begin
      if (step) begin
        next_st.down = !dirUp;
      end
    end else if (!center) begin
      next_st.down = (cfg.cntMode == pctu_pkg::CNT_DOWN);
      dirUp        = (cfg.cntMode != pctu_pkg::CNT_DOWN);
    end
    // Counter with auto-reload
    if (step) begin
      if (dirUp) begin
        if (st.cnt >= cfg.autoReload) begin
          upd = 1'b1;
          if (center) begin
            next_st.down = 1'b1;
            next_st.cnt  = (cfg.autoReload != pctu_pkg::CNT_RESET) ? cfg.autoReload - pctu_pkg::CNT_ONE
                                                                   : pctu_pkg::CNT_RESET;
          end else begin
            next_st.cnt = pctu_pkg::CNT_RESET;
          end
        end else begin
          next_st.cnt = st.cnt + pctu_pkg::CNT_ONE;
        end
      end else begin
        if (st.cnt == pctu_pkg::CNT_RESET || st.cnt > cfg.autoReload) begin
          upd = 1'b1;
          if (center) begin
            next_st.down = 1'b0;
            next_st.cnt  = (cfg.autoReload != pctu_pkg::CNT_RESET) ? pctu_pkg::CNT_ONE : pctu_pkg::CNT_RESET;
          end else begin
            next_st.cnt = cfg.autoReload;
          end
        end else begin
          next_st.cnt = st.cnt - pctu_pkg::CNT_ONE;
        end
      end
    end
    // Link reset restarts the count
    if (cfg.slave == pctu_pkg::SLV_RESET && linkTrigIn) begin
      next_st.cnt = pctu_pkg::CNT_RESET;
      next_st.psc = pctu_pkg::CNT_RESET;
      upd         = 1'b1;
    end
    // Hall change captures the interval and restarts the count
    if (cfg.src == pctu_pkg::SRC_HALL && (^filt.hall) != (^filtPrev.hall)) begin
      next_st.cap[0]   = st.cnt;
      next_st.dmaCh[0] = 1'b1;
      next_st.cnt      = pctu_pkg::CNT_RESET;
      next_st.psc      = pctu_pkg::CNT_RESET;
    end
    // Channel events
    for (int i = 0; i < pctu_pkg::NUM_CH; i++) begin
      if (chCfg[i].mode == pctu_pkg::CH_CAPTURE) begin
        if (filt.capIn[i] != filtPrev.capIn[i] && filt.capIn[i] != chCfg[i].captureFalling) begin
          next_st.cap[i]   = st.cnt;
          next_st.dmaCh[i] = 1'b1;
        end
      end else if (match[i] && st.stepped) begin
        next_st.dmaCh[i] = 1'b1;
        if (chCfg[i].mode == pctu_pkg::CH_COMPARE) begin
          next_st.toggle[i] = !st.toggle[i];
        end
      end
      // One-pulse stops the counter at the end of its period
      if (upd && chCfg[i].mode == pctu_pkg::CH_ONEPULSE) begin
        next_st.stopped = 1'b1;
      end
    end
    next_st.stepped = step;
    next_st.upd     = upd;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Channels
  for (genvar i = 0; i < pctu_pkg::NUM_CH; i++) begin : gCh
    pctu_channel uChannel (
      .mode     (chCfg[i].mode),
      .compare  (chCfg[i].compare),
      .count    (st.cnt),
      .toggle   (st.toggle[i]),
      .refLevel (refLevel[i]),
      .match    (match[i])
    );
  end

  // ==========================================================
  // Output stage: pairs with dead-time on the advanced timer only
  if (ADVANCED) begin : gAdv
    for (genvar p = 0; p < pctu_pkg::NUM_PAIRS; p++) begin : gPair
      pctu_deadtime #(.DT_W(pctu_pkg::DT_W)) uDeadtime (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .refLevel (refLevel[p]),
        .deadTime (cfg.deadTime),
        .mainOut  (rawMain[p]),
        .compOut  (rawComp[p])
      );
    end
    assign rawMain[3] = refLevel[3];
    assign estopAsync = pins.estop;
    assign forceSafe  = filt.estop || (debugHalt && cfg.stopOutputsInDebug);
  end else begin : gGen
    assign rawMain    = refLevel;
    assign rawComp    = 3'h0;
    assign estopAsync = 1'b0;
    assign forceSafe  = 1'b0;
  end

  // Output flops, forced safe at once by emergency stop on the advanced timer
  always_ff @(posedge ref_clk or posedge estopAsync) begin
    if (estopAsync) begin
      chOut   <= SAFE_MAIN;
      compOut <= SAFE_COMP;
    end else if (rst || forceSafe) begin
      chOut   <= SAFE_MAIN;
      compOut <= SAFE_COMP;
    end else begin
      chOut   <= rawMain;
      compOut <= rawComp;
    end
  end

  // Status and request outputs straight from state flops
  assign count       = st.cnt;
  assign capture     = st.cap;
  assign countDown   = st.down;
  assign linkTrigOut = st.upd;
  assign dmaUpdate   = st.upd;
  assign dmaChannel  = st.dmaCh;

  // ==========================================================
  // Assertions
  AST_PSC_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(active) && !$past(hold) && $past(st.psc) >= $past(cfg.prescale) && $past(cfg.slave) == pctu_pkg::SLV_OFF
     && $past(cfg.src) == pctu_pkg::SRC_INTERNAL) |-> st.psc == 16'h0000 && st.stepped)
    else $error("Prescaler did not wrap at its factor");

  AST_UP_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (dmaUpdate && $past(cfg.cntMode) == pctu_pkg::CNT_UP && $past(cfg.src) == pctu_pkg::SRC_INTERNAL) |-> count == 16'h0000)
    else $error("Up counter did not restart at zero");

  AST_DOWN_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (dmaUpdate && $past(cfg.cntMode) == pctu_pkg::CNT_DOWN && $past(cfg.src) == pctu_pkg::SRC_INTERNAL
     && $past(cfg.slave) != pctu_pkg::SLV_RESET) |-> count == $past(cfg.autoReload))
    else $error("Down counter did not reload");

  AST_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst)
    (dmaChannel[1] && $past(chCfg[1].mode) == pctu_pkg::CH_CAPTURE) |-> capture[1] == $past(count))
    else $error("Captured value differs from counter");

  AST_FULL_ON: assert property (@(posedge ref_clk) disable iff (rst)
    (chCfg[3].mode == pctu_pkg::CH_PWM && chCfg[3].compare > cfg.autoReload && count <= cfg.autoReload
     && !forceSafe) |=> chOut[3] || pins.estop)
    else $error("Duty above top is not fully on");

  AST_DEBUG_SAFE: assert property (@(posedge ref_clk) disable iff (rst)
    (ADVANCED && debugHalt && cfg.stopOutputsInDebug) |=> chOut == SAFE_MAIN && compOut == SAFE_COMP)
    else $error("Outputs not safe during debug halt");

  AST_DEBUG_FREEZE: assert property (@(posedge ref_clk) disable iff (rst)
    (debugHalt && cfg.freezeInDebug && cfg.src == pctu_pkg::SRC_INTERNAL && cfg.slave == pctu_pkg::SLV_OFF)
    |=> $stable(count))
    else $error("Counter moved while frozen");

  AST_ESTOP: assert property (@(posedge ref_clk) disable iff (rst)
    (ADVANCED && pins.estop) |-> chOut == SAFE_MAIN && compOut == SAFE_COMP)
    else $error("Emergency stop did not force safe outputs");

  AST_NO_COMP: assert property (@(posedge ref_clk) disable iff (rst)
    !ADVANCED |-> compOut == 3'h0)
    else $error("General timer drove a complementary output");

endmodule : pctu_timer
`default_nettype wire
